// *** hdl/pst_pkg.sv ***
// Constants shared by the sparse I/O and configuration address translator
package pst_pkg;

  // ****************************************************************
  // Host address windows
  // ****************************************************************
  localparam int HOST_ADDR_W = 34;
  localparam int WIN_HI = 33;
  localparam int WIN_LO = 29;
  localparam logic [4:0] WIN_SPARSE_IO = 5'h0e;
  localparam logic [4:0] WIN_CONFIG = 5'h0f;

  // ****************************************************************
  // Host address fields
  // ****************************************************************
  localparam int EXT_SEL_HI = 28;
  localparam int EXT_SEL_LO = 23;
  localparam int QW_HI = 28;
  localparam int QW_LO = 8;
  localparam int ODD_LW_BIT = 7;
  localparam int LANE_HI = 6;
  localparam int LANE_LO = 5;
  localparam int LEN_HI = 4;
  localparam int LEN_LO = 3;
  localparam int BUS_HI = 28;
  localparam int BUS_LO = 21;
  localparam int DEV_HI = 20;
  localparam int DEV_LO = 16;
  localparam int FUNC_HI = 15;
  localparam int FUNC_LO = 13;
  localparam int REG_HI = 12;
  localparam int REG_LO = 7;

  // ****************************************************************
  // PCI commands
  // ****************************************************************
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;

  // ****************************************************************
  // Length and lane codes, byte enables
  // ****************************************************************
  localparam logic [1:0] LEN_BYTE = 2'h0;
  localparam logic [1:0] LEN_WORD = 2'h1;
  localparam logic [1:0] LEN_TRI = 2'h2;
  localparam logic [1:0] LEN_LONG = 2'h3;
  localparam logic [1:0] LANE_QUAD = 2'h3;
  localparam logic [3:0] BE_ALL = 4'h0;
  localparam logic [3:0] BE_NONE = 4'hf;

  // ****************************************************************
  // Extension register, configuration target
  // ****************************************************************
  localparam logic [7:0] FIXED_ZERO_EXT = 8'h00;
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [1:0] BUS_PRIMARY = 2'h0;
  localparam logic [1:0] BUS_SECONDARY = 2'h1;
  localparam logic [4:0] IDSEL_DEVICES = 5'h15;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam logic [3:0] ADDR_HOLD_CYCLES = 4'h2;

endpackage : pst_pkg

// *** hdl/pst_lane_dec.sv ***
// Byte enable and low address decoder for sparse accesses
`timescale 1ns/1ns
module pst_lane_dec (
  input wire logic [1:0] lane,
  input wire logic [1:0] len,
  input wire logic addr7,
  output logic [3:0] be_n,
  output logic [2:0] ad_lo
);

  always_comb begin
    ad_lo = {addr7, lane};
    be_n = pst_pkg::BE_NONE;
    unique case (len)
      pst_pkg::LEN_BYTE: begin
        be_n = ~(4'h1 << lane);
      end
      pst_pkg::LEN_WORD: begin
        if (lane != 2'h3) begin
          be_n = ~(4'h3 << lane);
        end
      end
      pst_pkg::LEN_TRI: begin
        if (lane[1] == 1'b0) begin
          be_n = ~(4'h7 << lane);
        end
      end
      pst_pkg::LEN_LONG: begin
        if (lane == 2'h0) begin
          be_n = pst_pkg::BE_ALL;
        end else if (lane == pst_pkg::LANE_QUAD) begin
          be_n = pst_pkg::BE_ALL;
          ad_lo = 3'h0;
        end
      end
    endcase
  end

endmodule : pst_lane_dec

// *** hdl/pst_translate.sv ***
// Host to PCI sparse I/O and configuration cycle address translator
`timescale 1ns/1ns
module pst_translate (
  input wire logic clk,
  input wire logic nrst,
  input wire logic host_req,
  input wire logic host_write,
  input wire logic [33:0] host_bus_address,
  input wire logic ext_wr,
  input wire logic [7:0] ext_wdata,
  output logic host_ready_q,
  output logic host_done_q,
  output logic host_miss_q,
  output logic pci_addr_phase_q,
  output logic [3:0] pci_cmd_q,
  output logic [31:0] pci_ad_q,
  output logic [3:0] pci_cbe_n_q,
  output logic [7:0] io_cfg_extension_reg
);

  // ****************************************************************
  // Types and decode helpers
  // ****************************************************************
  typedef enum logic {PST_IDLE, PST_ADDR} pst_state_e;

  function automatic logic [20:0] idsel_decode(input logic [4:0] dev);
    idsel_decode = 21'h0;
    if (dev < pst_pkg::IDSEL_DEVICES) begin
      idsel_decode = 21'h1 << dev;
    end
  endfunction : idsel_decode

  pst_state_e state_q;
  logic [3:0] hold_cnt_q;
  logic [4:0] win;
  logic is_io;
  logic is_cfg;
  logic take;
  logic cfg_primary;
  logic [7:0] io_ext;
  logic [31:0] ad_d;
  logic [3:0] cmd_d;
  logic [3:0] lane_be_n;
  logic [2:0] lane_ad_lo;
  logic [33:0] a;

  assign a = host_bus_address;

  // ****************************************************************
  // Window decode and address composition
  // ****************************************************************
  pst_lane_dec u_lane (
    .lane(a[pst_pkg::LANE_HI:pst_pkg::LANE_LO]),
    .len(a[pst_pkg::LEN_HI:pst_pkg::LEN_LO]),
    .addr7(a[pst_pkg::ODD_LW_BIT]),
    .be_n(lane_be_n),
    .ad_lo(lane_ad_lo)
  );

  always_comb begin
    win = a[pst_pkg::WIN_HI:pst_pkg::WIN_LO];
    is_io = (win == pst_pkg::WIN_SPARSE_IO);
    is_cfg = (win == pst_pkg::WIN_CONFIG);
    take = host_req && host_ready_q;
    cfg_primary = (io_cfg_extension_reg[1:0] == pst_pkg::BUS_PRIMARY);
    if (a[pst_pkg::EXT_SEL_HI:pst_pkg::EXT_SEL_LO] == 6'h00) begin
      io_ext = pst_pkg::FIXED_ZERO_EXT;
    end else begin
      io_ext = io_cfg_extension_reg;
    end
    if (is_io) begin
      ad_d = {io_ext, a[pst_pkg::QW_HI:pst_pkg::QW_LO], lane_ad_lo};
      cmd_d = host_write ? pst_pkg::CMD_IO_WR : pst_pkg::CMD_IO_RD;
    end else if (cfg_primary) begin
      ad_d = {idsel_decode(a[pst_pkg::DEV_HI:pst_pkg::DEV_LO]),
              a[pst_pkg::FUNC_HI:pst_pkg::FUNC_LO], a[pst_pkg::REG_HI:pst_pkg::REG_LO],
              io_cfg_extension_reg[1:0]};
      cmd_d = host_write ? pst_pkg::CMD_CFG_WR : pst_pkg::CMD_CFG_RD;
    end else begin
      // Upper byte is a constant, never the extension register
      ad_d = {8'h00, a[pst_pkg::BUS_HI:pst_pkg::BUS_LO],
              a[pst_pkg::DEV_HI:pst_pkg::DEV_LO], a[pst_pkg::FUNC_HI:pst_pkg::FUNC_LO],
              a[pst_pkg::REG_HI:pst_pkg::REG_LO],
              io_cfg_extension_reg[1:0]};
      cmd_d = host_write ? pst_pkg::CMD_CFG_WR : pst_pkg::CMD_CFG_RD;
    end
  end

  // ****************************************************************
  // Extension register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      io_cfg_extension_reg <= pst_pkg::EXT_RESET;
    end else if (ext_wr) begin
      io_cfg_extension_reg <= ext_wdata;
    end
  end

  // ****************************************************************
  // Cycle sequencer
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= PST_IDLE;
      hold_cnt_q <= 4'h0;
      host_ready_q <= 1'b0;
      host_done_q <= 1'b0;
      host_miss_q <= 1'b0;
      pci_addr_phase_q <= 1'b0;
    end else begin
      host_done_q <= 1'b0;
      host_miss_q <= 1'b0;
      unique case (state_q)
        PST_IDLE: begin
          host_ready_q <= 1'b1;
          if (take && (is_io || is_cfg)) begin
            // Invalid length/lane codes are still run to completion
            state_q <= PST_ADDR;
            host_ready_q <= 1'b0;
            pci_addr_phase_q <= 1'b1;
            hold_cnt_q <= 4'h1;
          end else if (take) begin
            host_miss_q <= 1'b1;
          end
        end
        PST_ADDR: begin
          if (hold_cnt_q == pst_pkg::ADDR_HOLD_CYCLES) begin
            state_q <= PST_IDLE;
            pci_addr_phase_q <= 1'b0;
            host_done_q <= 1'b1;
            host_ready_q <= 1'b1;
          end else begin
            hold_cnt_q <= hold_cnt_q + 4'h1;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Address phase registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pci_ad_q <= 32'h0;
      pci_cmd_q <= 4'h0;
      pci_cbe_n_q <= pst_pkg::BE_NONE;
    end else if (state_q == PST_IDLE && take && (is_io || is_cfg)) begin
      pci_ad_q <= ad_d;
      pci_cmd_q <= cmd_d;
      pci_cbe_n_q <= lane_be_n;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic acc_io;
  logic acc_cfg;
  assign acc_io = take && is_io && state_q == PST_IDLE;
  assign acc_cfg = take && is_cfg && state_q == PST_IDLE;

  win_miss_a: assert property (take && state_q == PST_IDLE && !is_io && !is_cfg
    |=> host_miss_q && !pci_addr_phase_q)
    else $error("unmapped host access not reported as miss");

  io_window_a: assert property (acc_io |=> pci_addr_phase_q ##1 pci_addr_phase_q)
    else $error("sparse I/O access did not start an address phase");

  io_cmd_a: assert property (acc_io
    |=> pci_cmd_q == ($past(host_write) ? pst_pkg::CMD_IO_WR : pst_pkg::CMD_IO_RD))
    else $error("wrong I/O command");

  io_qw_addr_a: assert property (acc_io
    |=> pci_ad_q[23:3] == $past(host_bus_address[28:8]))
    else $error("quadword address not on AD 23:3");

  io_zero_ext_a: assert property (acc_io && a[28:23] == 6'h00
    |=> pci_ad_q[31:24] == 8'h00)
    else $error("low I/O region not mapped by zero extension");

  io_prog_ext_a: assert property (acc_io && a[28:23] != 6'h00
    |=> pci_ad_q[31:24] == $past(io_cfg_extension_reg))
    else $error("upper I/O region not mapped by extension register");

  byte_en_a: assert property (acc_io && a[4:3] == pst_pkg::LEN_BYTE
    |=> pci_cbe_n_q == ~(4'h1 << $past(host_bus_address[6:5])))
    else $error("byte length enable pattern wrong");

  word_en_a: assert property (acc_io && a[4:3] == pst_pkg::LEN_WORD && a[6:5] == 2'h0
    |=> pci_cbe_n_q == 4'hc)
    else $error("word enable pattern wrong");

  tri_en_a: assert property (acc_io && a[4:3] == pst_pkg::LEN_TRI && a[6:5] == 2'h1
    |=> pci_cbe_n_q == 4'h1)
    else $error("tribyte enable pattern wrong");

  ad_low_a: assert property (acc_io && a[6:3] != 4'hf
    |=> pci_ad_q[2:0] == {$past(host_bus_address[7]), $past(host_bus_address[6:5])})
    else $error("AD 2:0 not taken from bits 7:5");

  quad_low_a: assert property (acc_io && a[6:3] == 4'hf
    |=> pci_ad_q[2:0] == 3'h0 && pci_cbe_n_q == 4'h0)
    else $error("quadword low address or enables wrong");

  invalid_done_a: assert property (acc_io && a[6:3] == 4'hd
    |-> ##[1:8] host_done_q)
    else $error("invalid length/lane access never completed");

  cfg_cmd_a: assert property (acc_cfg
    |=> pci_cmd_q == ($past(host_write) ? pst_pkg::CMD_CFG_WR : pst_pkg::CMD_CFG_RD))
    else $error("wrong configuration command");

  cfg_target_a: assert property (acc_cfg
    |=> pci_ad_q[1:0] == $past(io_cfg_extension_reg[1:0]))
    else $error("AD 1:0 not from extension register");

  cfg_fields_a: assert property (acc_cfg
    |=> pci_ad_q[10:2] == $past(host_bus_address[15:7]))
    else $error("function or register number misplaced");

  idsel_onehot_a: assert property (acc_cfg && cfg_primary
    |=> ($past(host_bus_address[20:16]) < pst_pkg::IDSEL_DEVICES)
      ? pci_ad_q[31:11] == (21'h1 << $past(host_bus_address[20:16]))
      : pci_ad_q[31:11] == 21'h0)
    else $error("device select pattern wrong");

  sec_fields_a: assert property (acc_cfg && !cfg_primary
    |=> pci_ad_q[31:24] == 8'h00 && pci_ad_q[23:11] == $past(host_bus_address[28:16]))
    else $error("secondary configuration fields wrong");

  hold_stable_a: assert property (pci_addr_phase_q && $past(pci_addr_phase_q)
    |-> $stable(pci_ad_q) && $stable(pci_cbe_n_q) && $stable(pci_cmd_q))
    else $error("address phase outputs changed");

  phase_len_a: assert property ($rose(pci_addr_phase_q)
    |-> pci_addr_phase_q [*2] ##1 (!pci_addr_phase_q && host_done_q))
    else $error("address phase length wrong");

  // ****************************************************************
  // Byte enable, extension, handshake and address phase assertions
  // ****************************************************************

  word_lane1_a: assert property (acc_io && a[4:3] == pst_pkg::LEN_WORD && a[6:5] == 2'h1
    |=> pci_cbe_n_q == 4'h9)
    else $error("word enable pattern wrong at lane 1");

  word_lane2_a: assert property (acc_io && a[4:3] == pst_pkg::LEN_WORD && a[6:5] == 2'h2
    |=> pci_cbe_n_q == 4'h3)
    else $error("word enable pattern wrong at lane 2");

  tri_lane0_a: assert property (acc_io && a[4:3] == pst_pkg::LEN_TRI && a[6:5] == 2'h0
    |=> pci_cbe_n_q == 4'h8)
    else $error("tribyte enable pattern wrong at lane 0");

  long_en_a: assert property (acc_io && a[6:3] == 4'h3
    |=> pci_cbe_n_q == 4'h0)
    else $error("longword enable pattern wrong");

  invalid_en_a: assert property (acc_io && (a[6:3] == 4'h7 || a[6:3] == 4'ha
    || a[6:3] == 4'hb || a[6:3] == 4'hd || a[6:3] == 4'he) |=> pci_cbe_n_q == 4'hf)
    else $error("invalid length/lane enables not all off");

  cfg_byte_a: assert property (acc_cfg && a[4:3] == pst_pkg::LEN_BYTE
    |=> pci_cbe_n_q == ~(4'h1 << $past(host_bus_address[6:5])))
    else $error("configuration byte enables wrong");

  cfg_word_a: assert property (acc_cfg && a[6:3] == 4'h1
    |=> pci_cbe_n_q == 4'hc)
    else $error("configuration word enables wrong");

  cfg_quad_a: assert property (acc_cfg && a[6:3] == 4'hf
    |=> pci_cbe_n_q == 4'h0)
    else $error("configuration quadword enables wrong");

  ext_load_a: assert property (ext_wr
    |=> io_cfg_extension_reg == $past(ext_wdata))
    else $error("extension register not loaded");

  ext_keep_a: assert property (!ext_wr
    |=> $stable(io_cfg_extension_reg))
    else $error("extension register changed without a write");

  busy_ready_a: assert property (pci_addr_phase_q
    |-> !host_ready_q)
    else $error("ready high during address phase");

  done_ready_a: assert property (host_done_q
    |-> host_ready_q && !pci_addr_phase_q)
    else $error("done without ready or with phase still open");

  miss_ready_a: assert property (host_miss_q
    |-> host_ready_q && !pci_addr_phase_q)
    else $error("miss dropped ready or opened a phase");

  idle_hold_a: assert property (!acc_io && !acc_cfg
    |=> $stable(pci_ad_q) && $stable(pci_cbe_n_q) && $stable(pci_cmd_q))
    else $error("address outputs changed without an accepted access");

  hold_count_a: assert property (state_q == PST_ADDR
    |-> hold_cnt_q != 4'h0 && hold_cnt_q <= pst_pkg::ADDR_HOLD_CYCLES)
    else $error("address phase counter out of range");

  phase_state_a: assert property (pci_addr_phase_q
    |-> state_q == PST_ADDR)
    else $error("address phase flag outside address state");

  primary_target_a: assert property (acc_cfg && cfg_primary
    |=> pci_ad_q[1:0] == 2'h0)
    else $error("primary configuration target code wrong");

  io_read_c: cover property (acc_io && !host_write ##1 pci_addr_phase_q);
  cfg_prim_c: cover property (acc_cfg && cfg_primary && host_write);
  cfg_sec_c: cover property (acc_cfg && !cfg_primary ##[1:4] host_done_q);
  miss_c: cover property (host_miss_q);
  ext_io_c: cover property (ext_wr ##1 acc_io);

endmodule : pst_translate

// *** verification/pst_pci_target_model.sv ***
// Model of the PCI targets watching translated address phases
`timescale 1ns/1ns
module pst_pci_target_model (
  input wire logic clk,
  input wire logic addr_phase,
  input wire logic [3:0] cmd,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  output logic [3:0] cap_cmd,
  output logic [31:0] cap_ad,
  output logic [3:0] cap_be_n,
  output logic [2:0] phase_len,
  output logic held,
  output logic [4:0] idsel_dev,
  output logic idsel_one
);
  // ****************************************************************
  // Address phase capture and target select
  // ****************************************************************
  logic in_q;

  always_ff @(posedge clk) begin
    in_q <= addr_phase;
    if (addr_phase && !in_q) begin
      cap_cmd <= cmd;
      cap_ad <= ad;
      cap_be_n <= cbe_n;
      phase_len <= 3'h1;
      held <= 1'b1;
    end else if (addr_phase) begin
      phase_len <= phase_len + 3'h1;
      held <= held && ad === cap_ad && cmd === cap_cmd && cbe_n === cap_be_n;
    end
  end

  // Each primary target owns one select line
  always_comb begin
    idsel_dev = 5'h1f;
    for (int i = 0; i < 21; i++) begin
      if (cap_ad[11+i]) begin
        idsel_dev = 5'(i);
      end
    end
  end
  assign idsel_one = $onehot(cap_ad[31:11]);
endmodule : pst_pci_target_model

// *** verification/testbench.sv ***
// Self-checking bench for the sparse I/O and configuration translator
`timescale 1ns/1ns
module testbench;
  // ****************************************************************
  // Signals, design and target model
  // ****************************************************************
  localparam logic [63:0] BE_TAB = 64'h0ff7ff3bf19d08ce;
  logic clk, nrst, host_req, host_write, ext_wr;
  logic [33:0] host_bus_address;
  logic [7:0] ext_wdata, io_cfg_extension_reg;
  logic host_ready_q, host_done_q, host_miss_q, pci_addr_phase_q, held, idsel_one;
  logic [3:0] pci_cmd_q, pci_cbe_n_q, cap_cmd, cap_be_n;
  logic [31:0] pci_ad_q, cap_ad;
  logic [2:0] phase_len;
  logic [4:0] idsel_dev;
  int errors;
  int checks;

  pst_translate pst_translate_i (.clk(clk), .nrst(nrst), .host_req(host_req),
    .host_write(host_write), .host_bus_address(host_bus_address), .ext_wr(ext_wr),
    .ext_wdata(ext_wdata), .host_ready_q(host_ready_q), .host_done_q(host_done_q),
    .host_miss_q(host_miss_q), .pci_addr_phase_q(pci_addr_phase_q), .pci_cmd_q(pci_cmd_q),
    .pci_ad_q(pci_ad_q), .pci_cbe_n_q(pci_cbe_n_q),
    .io_cfg_extension_reg(io_cfg_extension_reg));

  pst_pci_target_model pst_pci_target_model_i (.clk(clk), .addr_phase(pci_addr_phase_q),
    .cmd(pci_cmd_q), .ad(pci_ad_q), .cbe_n(pci_cbe_n_q), .cap_cmd(cap_cmd), .cap_ad(cap_ad),
    .cap_be_n(cap_be_n), .phase_len(phase_len), .held(held), .idsel_dev(idsel_dev),
    .idsel_one(idsel_one));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test();
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic write_ext(input logic [7:0] v);
    @(posedge clk);
    ext_wr <= 1'b1;
    ext_wdata <= v;
    @(posedge clk);
    ext_wr <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'(io_cfg_extension_reg), 32'(v), "ext readback");
  endtask : write_ext

  task automatic access(input logic wr, input logic [33:0] a);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (host_ready_q !== 1'b1 && n < 50);
    if (host_ready_q !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t ready never seen", $time);
      stop_test();
    end
    @(posedge clk);
    host_req <= 1'b1;
    host_write <= wr;
    host_bus_address <= a;
    @(posedge clk);
    host_req <= 1'b0;
    #1;
    while (host_done_q !== 1'b1 && host_miss_q !== 1'b1 && n < 80) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (host_done_q !== 1'b1 && host_miss_q !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t access timed out", $time);
      stop_test();
    end
  endtask : access

  task automatic hit(input logic wr, input logic [33:0] a, input logic [3:0] cmd,
                     input logic [31:0] ad, input logic [3:0] be);
    access(wr, a);
    chk(32'(host_done_q), 32'h1, "done");
    chk(32'(cap_cmd), 32'(cmd), "command");
    chk(cap_ad, ad, "address");
    chk(32'(cap_be_n), 32'(be), "byte enables");
    chk(32'(phase_len), 32'h2, "phase length");
    chk(32'(held), 32'h1, "phase hold");
  endtask : hit

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_io_lanes();
    logic [33:0] a;
    for (int b = 0; b < 15; b++) begin
      a = 34'h1_c012_3400 | (34'(b) << 3) | (34'(b % 2) << 7);
      hit(a[3], a, a[3] ? pst_pkg::CMD_IO_WR : pst_pkg::CMD_IO_RD,
          {8'h00, a[28:8], a[7], a[6:5]}, BE_TAB[4*b +: 4]);
    end
  endtask : t_io_lanes

  task automatic t_io_ext();
    logic [33:0] a;
    write_ext(8'ha5);
    a = 34'h1_dabc_de40;
    hit(1'b1, a, pst_pkg::CMD_IO_WR, {8'ha5, a[28:8], a[7], a[6:5]}, 4'hb);
    a = 34'h1_c07f_ff98;
    hit(1'b0, a, pst_pkg::CMD_IO_RD, {8'h00, a[28:8], 3'h4}, 4'h0);
  endtask : t_io_ext

  task automatic t_cfg_primary();
    logic [33:0] a;
    logic [20:0] sel;
    write_ext(8'hfc);
    for (int d = 0; d < 32; d++) begin
      a = 34'h1_fe00_0000 | (34'(d) << 16) | (34'(d) << 9) | (34'(d % 16) << 3);
      sel = d < 21 ? 21'h1 << d : 21'h0;
      hit(a[16], a, a[16] ? pst_pkg::CMD_CFG_WR : pst_pkg::CMD_CFG_RD,
          {sel, a[15:13], a[12:7], 2'b00}, BE_TAB[4*(d%16) +: 4]);
      chk(32'(idsel_one), 32'(d < 21), "one select line");
      if (d < 21) begin
        chk(32'(idsel_dev), 32'(d), "select line");
      end else begin
        chk(32'(idsel_dev), 32'h1f, "no select line");
      end
    end
  endtask : t_cfg_primary

  task automatic t_cfg_secondary();
    logic [33:0] a;
    write_ext(8'hfd);
    a = 34'h1_f5a5_b3c0;
    for (int w = 0; w < 2; w++) begin
      hit(w[0], a, w[0] ? pst_pkg::CMD_CFG_WR : pst_pkg::CMD_CFG_RD,
          {8'h00, a[28:21], a[20:16], a[15:13], a[12:7], 2'b01}, 4'hb);
    end
  endtask : t_cfg_secondary

  task automatic t_miss();
    logic [33:0] tab [4] = '{34'h1_a000_0000, 34'h2_0000_0000, 34'h1_bfff_fff8, 34'h0_0000_0000};
    for (int i = 0; i < 4; i++) begin
      access(1'b0, tab[i]);
      chk(32'(host_miss_q), 32'h1, "miss");
      chk(32'(host_done_q), 32'h0, "no done on miss");
    end
  endtask : t_miss

  initial begin
    errors = 0;
    checks = 0;
    nrst = 1'b0;
    host_req = 1'b0;
    host_write = 1'b0;
    host_bus_address = '0;
    ext_wr = 1'b0;
    ext_wdata = '0;
    repeat (5) @(posedge clk);
    #1;
    chk(32'(host_ready_q), 32'h0, "ready in reset");
    chk(32'(io_cfg_extension_reg), 32'h0, "ext in reset");
    chk(32'(pci_cbe_n_q), 32'hf, "enables in reset");
    chk(32'(pci_addr_phase_q), 32'h0, "phase in reset");
    @(posedge clk);
    nrst <= 1'b1;
    t_io_lanes();
    t_io_ext();
    t_cfg_primary();
    t_cfg_secondary();
    t_miss();
    stop_test();
  end
endmodule : testbench
